// *** hw/spg_ctrl.sv ***
// How it works
// (RULE1) Lockout flags set regardless of lockout enables
// (RULE2) Under-lockout enabled and low: both gates off
// (RULE3) Under-lockout clears itself when supply recovers
// (RULE4) Over-lockout enabled and high: both gates off
// (RULE5) Over-lockout clears itself when supply falls
// (RULE6) Flags set regardless of enables or global enable
// (RULE7) Control bits 7..4 under, 3..0 over
// (RULE8) Lockout status bits read-only, show comparator
// (RULE9) Under-lockout edge enables select flag-setting edges
// (RULE10) Over-lockout edge enables select flag-setting edges
// (RULE11) Six-bit under-lockout code, upper bits zero
// (RULE12) Six-bit over-lockout code, upper bits zero
// (RULE13) Output overvoltage: secondary high, primary low
// (RULE14) Overvoltage control bits 3..0, 7..4 zero
// (RULE15) Overvoltage status bit shows comparator state
// (RULE16) Overvoltage edge enables select flag-setting edges
// (RULE17) Eight-bit reference code feeds the DAC
// (RULE18) Reference on inverting input versus divided output
// (RULE19) Two-flop sync, flags sticky until cleared
// (RULE20) Gate overrides follow synchronized faults promptly
`timescale 1ns/1ps
`default_nettype none

module spg_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Analog comparator outputs, high means fault
  input wire logic under_lockout_cmp,
  input wire logic over_lockout_cmp,
  input wire logic output_overvoltage_cmp,
  // Gate requests from the modulator
  input wire logic primary_gate_req,
  input wire logic secondary_gate_req,
  // Threshold codes to the analog references
  output logic [5:0] under_lockout_code,
  output logic [5:0] over_lockout_code,
  output logic [7:0] output_overvoltage_code,
  // Protected gate drives
  output logic primary_gate_drive,
  output logic secondary_gate_drive,
  // Sticky flags toward the interrupt flag register
  output logic under_lockout_irq_flag,
  output logic over_lockout_irq_flag,
  output logic output_overvoltage_irq_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  spg_pkg::spg_state_t st_reg; // All registered state
  spg_pkg::spg_state_t st_next; // Next value of all state

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection helper

  // Flag-setting event from an edge and its enables
  function automatic logic spg_edge_hit(input spg_pkg::spg_chan_sync_t s,
                                        input spg_pkg::spg_chan_cfg_t c);
    logic rise;
    logic fall;
    rise = s.sync & ~s.prev;
    fall = ~s.sync & s.prev;
    spg_edge_hit = (rise & c.rise_en) | (fall & c.fall_en);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Bus decode, synchronisers, flags and gate overrides
  always_comb begin
    logic wr_hit;
    logic rd_hit;
    logic ul_evt;
    logic ol_evt;
    logic ov_evt;
    logic lockout;
    logic ov_fault;
    logic [7:0] wb;
    logic [31:0] rd;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    ul_evt = 1'b0;
    ol_evt = 1'b0;
    ov_evt = 1'b0;
    lockout = 1'b0;
    ov_fault = 1'b0;
    wb = avs_writedata[7:0];
    rd = spg_pkg::SPG_READ_UNMAPPED;
    st_next = st_reg;

    // Two-flop synchronisers; first flop feeds only the second
    st_next.ul_s.meta = under_lockout_cmp; // [RULE19]
    st_next.ul_s.sync = st_reg.ul_s.meta; // [RULE19]
    st_next.ul_s.prev = st_reg.ul_s.sync;
    st_next.ol_s.meta = over_lockout_cmp; // [RULE19]
    st_next.ol_s.sync = st_reg.ol_s.meta; // [RULE19]
    st_next.ol_s.prev = st_reg.ol_s.sync;
    st_next.ov_s.meta = output_overvoltage_cmp; // [RULE19] [RULE18]
    st_next.ov_s.sync = st_reg.ov_s.meta;
    st_next.ov_s.prev = st_reg.ov_s.sync;

    // Edge events ignore the module enables entirely
    ul_evt = spg_edge_hit(st_reg.ul_s, st_reg.ul_cfg); // [RULE9] [RULE1] [RULE6]
    ol_evt = spg_edge_hit(st_reg.ol_s, st_reg.ol_cfg); // [RULE10] [RULE1] [RULE6]
    ov_evt = spg_edge_hit(st_reg.ov_s, st_reg.ov_cfg); // [RULE16] [RULE6]

    // One wait state: waitrequest drops the cycle after a request,
    // so registered read data already stands at the accepting edge
    st_next.waitrequest = ~((avs_read | avs_write) & st_reg.waitrequest);
    wr_hit = avs_write & ~st_reg.waitrequest & avs_byteenable[0];
    rd_hit = avs_read & st_reg.waitrequest;

    // Register writes; only the low byte lane carries data
    if (wr_hit) begin
      unique case (avs_address)
        {1'b0, spg_pkg::SPG_OFF_SUPPLY_GUARD_CONTROL}: begin
          // Status bits are read-only and not stored
          st_next.ul_cfg.enable = wb[spg_pkg::SPG_UL_EN_BIT]; // [RULE7]
          st_next.ul_cfg.rise_en = wb[spg_pkg::SPG_UL_RISE_BIT]; // [RULE7]
          st_next.ul_cfg.fall_en = wb[spg_pkg::SPG_UL_FALL_BIT];
          st_next.ol_cfg.enable = wb[spg_pkg::SPG_OL_EN_BIT];
          st_next.ol_cfg.rise_en = wb[spg_pkg::SPG_OL_RISE_BIT];
          st_next.ol_cfg.fall_en = wb[spg_pkg::SPG_OL_FALL_BIT];
        end
        {1'b0, spg_pkg::SPG_OFF_UNDER_LOCKOUT_LEVEL}: begin
          st_next.under_lockout_code = wb[5:0]; // [RULE11]
        end
        {1'b0, spg_pkg::SPG_OFF_OVER_LOCKOUT_LEVEL}: begin
          st_next.over_lockout_code = wb[5:0]; // [RULE12]
        end
        {1'b0, spg_pkg::SPG_OFF_OUTPUT_OV_CONTROL}: begin
          st_next.ov_cfg.enable = wb[spg_pkg::SPG_OV_EN_BIT]; // [RULE14]
          st_next.ov_cfg.rise_en = wb[spg_pkg::SPG_OV_RISE_BIT];
          st_next.ov_cfg.fall_en = wb[spg_pkg::SPG_OV_FALL_BIT];
        end
        spg_pkg::SPG_OFF_OUTPUT_OV_REFERENCE_W: begin
          st_next.output_overvoltage_code = wb; // [RULE17]
        end
        spg_pkg::SPG_OFF_IRQ_FLAGS: begin
          // Write one to clear; handled below so a set wins
        end
        default: begin
          // Unmapped write is ignored
        end
      endcase
    end

    // Sticky flags: clear on write-one, a same-cycle event wins
    if (wr_hit && avs_address == spg_pkg::SPG_OFF_IRQ_FLAGS) begin
      if (wb[spg_pkg::SPG_IF_UL_BIT]) begin
        st_next.under_lockout_irq_flag = 1'b0;
      end
      if (wb[spg_pkg::SPG_IF_OL_BIT]) begin
        st_next.over_lockout_irq_flag = 1'b0;
      end
      if (wb[spg_pkg::SPG_IF_OV_BIT]) begin
        st_next.output_overvoltage_irq_flag = 1'b0;
      end
    end
    if (ul_evt) begin
      st_next.under_lockout_irq_flag = 1'b1; // [RULE19]
    end
    if (ol_evt) begin
      st_next.over_lockout_irq_flag = 1'b1; // [RULE19]
    end
    if (ov_evt) begin
      st_next.output_overvoltage_irq_flag = 1'b1; // [RULE19]
    end

    // Read mux; reserved and unmapped bits read zero
    unique case (avs_address)
      {1'b0, spg_pkg::SPG_OFF_SUPPLY_GUARD_CONTROL}: begin
        rd[spg_pkg::SPG_UL_EN_BIT] = st_reg.ul_cfg.enable; // [RULE7]
        rd[spg_pkg::SPG_UL_STAT_BIT] = st_reg.ul_s.sync; // [RULE8]
        rd[spg_pkg::SPG_UL_RISE_BIT] = st_reg.ul_cfg.rise_en;
        rd[spg_pkg::SPG_UL_FALL_BIT] = st_reg.ul_cfg.fall_en;
        rd[spg_pkg::SPG_OL_EN_BIT] = st_reg.ol_cfg.enable;
        rd[spg_pkg::SPG_OL_STAT_BIT] = st_reg.ol_s.sync; // [RULE8]
        rd[spg_pkg::SPG_OL_RISE_BIT] = st_reg.ol_cfg.rise_en;
        rd[spg_pkg::SPG_OL_FALL_BIT] = st_reg.ol_cfg.fall_en;
      end
      {1'b0, spg_pkg::SPG_OFF_UNDER_LOCKOUT_LEVEL}: begin
        rd[5:0] = st_reg.under_lockout_code; // [RULE11]
      end
      {1'b0, spg_pkg::SPG_OFF_OVER_LOCKOUT_LEVEL}: begin
        rd[5:0] = st_reg.over_lockout_code; // [RULE12]
      end
      {1'b0, spg_pkg::SPG_OFF_OUTPUT_OV_CONTROL}: begin
        rd[spg_pkg::SPG_OV_EN_BIT] = st_reg.ov_cfg.enable; // [RULE14]
        rd[spg_pkg::SPG_OV_STAT_BIT] = st_reg.ov_s.sync; // [RULE15]
        rd[spg_pkg::SPG_OV_RISE_BIT] = st_reg.ov_cfg.rise_en;
        rd[spg_pkg::SPG_OV_FALL_BIT] = st_reg.ov_cfg.fall_en;
      end
      spg_pkg::SPG_OFF_OUTPUT_OV_REFERENCE_W: begin
        rd[7:0] = st_reg.output_overvoltage_code;
      end
      spg_pkg::SPG_OFF_IRQ_FLAGS: begin
        rd[spg_pkg::SPG_IF_UL_BIT] = st_reg.under_lockout_irq_flag;
        rd[spg_pkg::SPG_IF_OL_BIT] = st_reg.over_lockout_irq_flag;
        rd[spg_pkg::SPG_IF_OV_BIT] = st_reg.output_overvoltage_irq_flag;
      end
      default: begin
        rd = spg_pkg::SPG_READ_UNMAPPED;
      end
    endcase
    // Readdata holds its last value between reads
    if (rd_hit) begin
      st_next.readdata = rd;
    end
    st_next.readdatavalid_unused = 1'b0;

    // Gate overrides from synchronized comparator levels.
    // Lockout drops as soon as the comparator falls back, no software step.
    lockout = (st_reg.ul_cfg.enable & st_reg.ul_s.sync) // [RULE2] [RULE3]
            | (st_reg.ol_cfg.enable & st_reg.ol_s.sync); // [RULE4] [RULE5]
    ov_fault = st_reg.ov_cfg.enable & st_reg.ov_s.sync; // [RULE13]
    // Lockout beats overvoltage: with supply out of range nothing switches
    if (lockout) begin
      st_next.primary_gate_drive = 1'b0; // [RULE20]
      st_next.secondary_gate_drive = 1'b0;
    end else if (ov_fault) begin
      st_next.primary_gate_drive = 1'b0; // [RULE13] [RULE20]
      st_next.secondary_gate_drive = 1'b1;
    end else begin
      st_next.primary_gate_drive = primary_gate_req;
      st_next.secondary_gate_drive = secondary_gate_req;
    end
    st_next.primary_force_low = lockout | ov_fault;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous active-low reset to constants
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.waitrequest <= 1'b1;
      st_reg.under_lockout_code <= spg_pkg::SPG_RST_LEVEL;
      st_reg.over_lockout_code <= spg_pkg::SPG_RST_LEVEL;
      st_reg.output_overvoltage_code <= spg_pkg::SPG_RST_REFERENCE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign avs_readdata = st_reg.readdata;
  assign avs_waitrequest = st_reg.waitrequest;
  assign under_lockout_code = st_reg.under_lockout_code; // [RULE11]
  assign over_lockout_code = st_reg.over_lockout_code; // [RULE12]
  assign output_overvoltage_code = st_reg.output_overvoltage_code; // [RULE17] [RULE18]
  assign primary_gate_drive = st_reg.primary_gate_drive;
  assign secondary_gate_drive = st_reg.secondary_gate_drive;
  assign under_lockout_irq_flag = st_reg.under_lockout_irq_flag;
  assign over_lockout_irq_flag = st_reg.over_lockout_irq_flag;
  assign output_overvoltage_irq_flag = st_reg.output_overvoltage_irq_flag;

endmodule

`default_nettype wire

// *** hw/spg_pkg.sv ***
package spg_pkg;

  // Register word offsets (byte addresses, one aligned word each)
  localparam logic [3:0] SPG_OFF_SUPPLY_GUARD_CONTROL = 4'h0;
  localparam logic [3:0] SPG_OFF_UNDER_LOCKOUT_LEVEL = 4'h4;
  localparam logic [3:0] SPG_OFF_OVER_LOCKOUT_LEVEL = 4'h8;
  localparam logic [3:0] SPG_OFF_OUTPUT_OV_CONTROL = 4'hc;
  localparam logic [3:0] SPG_OFF_OUTPUT_OV_REFERENCE = 4'h0;
  localparam logic [4:0] SPG_OFF_OUTPUT_OV_REFERENCE_W = 5'h10;
  localparam logic [4:0] SPG_OFF_IRQ_FLAGS = 5'h14;

  // Supply guard control field positions
  localparam int SPG_UL_EN_BIT = 7;
  localparam int SPG_UL_STAT_BIT = 6;
  localparam int SPG_UL_RISE_BIT = 5;
  localparam int SPG_UL_FALL_BIT = 4;
  localparam int SPG_OL_EN_BIT = 3;
  localparam int SPG_OL_STAT_BIT = 2;
  localparam int SPG_OL_RISE_BIT = 1;
  localparam int SPG_OL_FALL_BIT = 0;

  // Output overvoltage control field positions
  localparam int SPG_OV_EN_BIT = 3;
  localparam int SPG_OV_STAT_BIT = 2;
  localparam int SPG_OV_RISE_BIT = 1;
  localparam int SPG_OV_FALL_BIT = 0;

  // Interrupt flag register field positions
  localparam int SPG_IF_UL_BIT = 0;
  localparam int SPG_IF_OL_BIT = 1;
  localparam int SPG_IF_OV_BIT = 2;

  // Reset values
  localparam logic [7:0] SPG_RST_CONTROL = 8'h00;
  localparam logic [5:0] SPG_RST_LEVEL = 6'h00;
  localparam logic [7:0] SPG_RST_REFERENCE = 8'h00;
  localparam logic [31:0] SPG_READ_UNMAPPED = 32'h00000000;

  // One comparator channel: enable, edge enables
  typedef struct packed {
    logic enable;
    logic rise_en;
    logic fall_en;
  } spg_chan_cfg_t;

  // Synchroniser and edge state of one comparator
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } spg_chan_sync_t;

  // Whole block state
  typedef struct packed {
    spg_chan_cfg_t ul_cfg;
    spg_chan_cfg_t ol_cfg;
    spg_chan_cfg_t ov_cfg;
    logic [5:0] under_lockout_code;
    logic [5:0] over_lockout_code;
    logic [7:0] output_overvoltage_code;
    spg_chan_sync_t ul_s;
    spg_chan_sync_t ol_s;
    spg_chan_sync_t ov_s;
    logic under_lockout_irq_flag;
    logic over_lockout_irq_flag;
    logic output_overvoltage_irq_flag;
    logic [31:0] readdata;
    logic waitrequest;
    logic readdatavalid_unused;
    logic primary_gate_drive;
    logic secondary_gate_drive;
    logic primary_force_low;
  } spg_state_t;

endpackage

// *** test/spg_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-side checker for the protection block
module spg_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic under_lockout_cmp,
  input wire logic over_lockout_cmp,
  input wire logic output_overvoltage_cmp,
  input wire logic primary_gate_req,
  input wire logic secondary_gate_req,
  input wire logic [5:0] under_lockout_code,
  input wire logic primary_gate_drive,
  input wire logic secondary_gate_drive,
  input wire logic under_lockout_irq_flag,
  input wire logic over_lockout_irq_flag,
  input wire logic output_overvoltage_irq_flag
);
  // Accepted write, low byte enabled
  wire logic acc = avs_write && !avs_waitrequest && avs_byteenable[0];
  logic [7:0] gctl_reg; // Shadow of supply guard control
  logic [7:0] octl_reg; // Shadow of overvoltage control
  // Shadows follow the bus so enables are known here
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gctl_reg <= 8'h00;
      octl_reg <= 8'h00;
    end else if (acc && avs_address == 5'h00) begin
      gctl_reg <= avs_writedata[7:0];
    end else if (acc && avs_address == 5'h0c) begin
      octl_reg <= avs_writedata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Four samples cover the two-flop sync plus the gate flop
  sequence s_ul; (under_lockout_cmp && gctl_reg[7])[*4]; endsequence
  sequence s_ol; (over_lockout_cmp && gctl_reg[3])[*4]; endsequence
  sequence s_quiet; (!under_lockout_cmp && !over_lockout_cmp && !output_overvoltage_cmp)[*4]; endsequence
  property p_ul_lock; s_ul |-> !primary_gate_drive && !secondary_gate_drive; endproperty
  property p_ol_lock; s_ol |-> !primary_gate_drive && !secondary_gate_drive; endproperty
  property p_ov_force;
    (output_overvoltage_cmp && octl_reg[3] && !under_lockout_cmp && !over_lockout_cmp)[*4]
      |-> secondary_gate_drive && !primary_gate_drive;
  endproperty
  property p_recover;
    s_quiet |-> primary_gate_drive == $past(primary_gate_req) && secondary_gate_drive == $past(secondary_gate_req);
  endproperty
  property p_ul_code;
    logic [5:0] d;
    (acc && avs_address == 5'h04, d = avs_writedata[5:0]) |=> under_lockout_code == d;
  endproperty
  // A flag may only rise three samples after its comparator moved
  property p_ulf; $rose(under_lockout_irq_flag) |-> $past(under_lockout_cmp, 3) != $past(under_lockout_cmp, 4); endproperty
  property p_olf; $rose(over_lockout_irq_flag) |-> $past(over_lockout_cmp, 3) != $past(over_lockout_cmp, 4); endproperty
  property p_ovf;
    $rose(output_overvoltage_irq_flag) |-> $past(output_overvoltage_cmp, 3) != $past(output_overvoltage_cmp, 4);
  endproperty
  property p_sticky;
    under_lockout_irq_flag && !(acc && avs_address == 5'h14 && avs_writedata[0]) |=> under_lockout_irq_flag;
  endproperty
  a_ul_lock: assert property (p_ul_lock) else $error("gates on in under lockout");
  a_ol_lock: assert property (p_ol_lock) else $error("gates on in over lockout");
  a_ov_force: assert property (p_ov_force) else $error("overvoltage gate states wrong");
  a_recover: assert property (p_recover) else $error("gates not following requests");
  a_ul_code: assert property (p_ul_code) else $error("under level code not updated");
  a_ulf: assert property (p_ulf) else $error("under flag without edge");
  a_olf: assert property (p_olf) else $error("over flag without edge");
  a_ovf: assert property (p_ovf) else $error("overvoltage flag without edge");
  a_sticky: assert property (p_sticky) else $error("under flag dropped uncleared");
endmodule
bind spg_ctrl spg_props u_props (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .under_lockout_cmp(under_lockout_cmp), .over_lockout_cmp(over_lockout_cmp),
  .output_overvoltage_cmp(output_overvoltage_cmp), .primary_gate_req(primary_gate_req),
  .secondary_gate_req(secondary_gate_req), .under_lockout_code(under_lockout_code),
  .primary_gate_drive(primary_gate_drive), .secondary_gate_drive(secondary_gate_drive),
  .under_lockout_irq_flag(under_lockout_irq_flag), .over_lockout_irq_flag(over_lockout_irq_flag),
  .output_overvoltage_irq_flag(output_overvoltage_irq_flag));
`default_nettype wire

// *** test/spg_analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Analog comparators; levels given in threshold-code units
module spg_analog_model (
  input wire logic [5:0] under_lockout_code,
  input wire logic [5:0] over_lockout_code,
  input wire logic [7:0] output_overvoltage_code,
  input wire logic [7:0] supply_level,
  input wire logic [7:0] output_level,
  output logic under_lockout_cmp,
  output logic over_lockout_cmp,
  output logic output_overvoltage_cmp
);
  // Threshold ladder is monotone in the code, so code order is enough
  assign under_lockout_cmp = supply_level < {2'h0, under_lockout_code};
  assign over_lockout_cmp = supply_level > {2'h0, over_lockout_code};
  // Divided output on plus input, reference DAC on minus input
  assign output_overvoltage_cmp = output_level > output_overvoltage_code;
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf; // Byte lane 0 always on
  logic primary_gate_req = 1'b0;
  logic secondary_gate_req = 1'b0;
  logic [7:0] supply_level = 8'h00; // Zero keeps all comparators quiet in reset
  logic [7:0] output_level = 8'h00;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, ul_cmp, ol_cmp, ov_cmp, pg, sg, ulf, olf, ovf;
  wire logic [5:0] ul_code, ol_code;
  wire logic [7:0] ov_code;
  int seed = 94350;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] exp_q [$]; // Expected read words, oldest first
  logic [31:0] rnd;
  logic [4:0] la [3] = '{5'h04, 5'h08, 5'h10}; // Level registers
  logic [7:0] lm [3] = '{8'h3f, 8'h3f, 8'hff}; // Their readable bits
  logic [7:0] gv [3] = '{8'h22, 8'h11, 8'hbb}; // Rise only, fall only, all on
  logic [7:0] ovv [3] = '{8'h02, 8'h01, 8'h0b};
  spg_ctrl u_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .under_lockout_cmp(ul_cmp),
    .over_lockout_cmp(ol_cmp), .output_overvoltage_cmp(ov_cmp), .primary_gate_req(primary_gate_req),
    .secondary_gate_req(secondary_gate_req), .under_lockout_code(ul_code), .over_lockout_code(ol_code),
    .output_overvoltage_code(ov_code), .primary_gate_drive(pg), .secondary_gate_drive(sg),
    .under_lockout_irq_flag(ulf), .over_lockout_irq_flag(olf), .output_overvoltage_irq_flag(ovf));
  spg_analog_model u_model (.under_lockout_code(ul_code), .over_lockout_code(ol_code),
    .output_overvoltage_code(ov_code), .supply_level(supply_level), .output_level(output_level),
    .under_lockout_cmp(ul_cmp), .over_lockout_cmp(ol_cmp), .output_overvoltage_cmp(ov_cmp));
  ////////////////////////////////////////////////////////////////
  // Clock and random gate requests
  always #12.5 clk = ~clk;
  always @(posedge clk) {primary_gate_req, secondary_gate_req} <= 2'($random(seed));
  // Read data stands at the edge where waitrequest is seen low
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) begin
      cmp_rd(avs_readdata, exp_q.pop_front());
    end
  end
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_gate(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: gates %b expected %b", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  // Push one channel across or back over its threshold, then settle
  task automatic fault(input int ch, input logic on);
    @(posedge clk);
    supply_level <= (ch == 0 && on) ? 8'h0a : (ch == 1 && on) ? 8'h32 : 8'h1e;
    output_level <= (ch == 2 && on) ? 8'h96 : 8'h32;
    repeat (6) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(5'h00, 32'h0);
    rd(5'h0c, 32'h0);
    // Codes are still zero: supply above over level, output above reference
    supply_level <= 8'h1e;
    output_level <= 8'h32;
    wr(5'h18, 32'hff);
    rd(5'h18, 32'h0);
    wr(5'h00, 32'hff);
    rd(5'h00, 32'hbf);
    wr(5'h0c, 32'hff);
    rd(5'h0c, 32'h0f);
    for (int i = 0; i < 3; i++) begin
      rnd = $random(seed);
      wr(la[i], rnd);
      rd(la[i], {24'h0, rnd[7:0] & lm[i]});
    end
    wr(5'h04, 32'h14);
    wr(5'h08, 32'h28);
    wr(5'h10, 32'h64);
    for (int m = 0; m < 3; m++) begin
      wr(5'h00, {24'h0, gv[m]});
      wr(5'h0c, {24'h0, ovv[m]});
      for (int ch = 0; ch < 3; ch++) begin
        fault(ch, 1'b0);
        wr(5'h14, 32'h7);
        fault(ch, 1'b1);
        rd(5'h14, (m != 1) ? 32'h1 << ch : 32'h0);
        rd((ch == 2) ? 5'h0c : 5'h00, {24'h0, ((ch == 2) ? ovv[m] : gv[m]) | ((ch == 0) ? 8'h40 : 8'h04)});
        if (m == 2) begin
          cmp_gate({pg, sg}, (ch == 2) ? 2'b01 : 2'b00);
        end
        wr(5'h14, 32'h7);
        rd(5'h14, 32'h0);
        fault(ch, 1'b0);
        rd(5'h14, (m != 0) ? 32'h1 << ch : 32'h0);
      end
    end
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
